// ---- sim/tb.sv ----
// bench for tmz_timer: bus calls with expected values, pin model on the count input
// assumes tmz_pkg, the checker and tmz_pin_src are compiled first
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tmz_pkg::*;
  logic clk = 1'h0, sys_rst = 1'h1, cyc = 1'h0, we = 1'h0, sleep = 1'h0, wdc = 1'h0, pin = 1'h0;
  logic ack, ext, irq, tick;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, rdat, q;
  int fails = 0, tests_run = 0, ticks = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) if (tick === 1'h1) ticks <= ticks + 1;
  tmz_timer i_tmz_timer (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .extCount(ext),
    .sleepMode(sleep), .watchdogClearInstr(wdc), .watchdogTick(tick), .irq(irq));
  tmz_pin_src i_tmz_pin_src (.clk(clk), .wantHigh(pin), .extCount(ext));
  task automatic final_report();
    $display("checks %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) fails++;
    if (s !== e) $display("[ERR] %s exp %h seen %h", nm, e, s);
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n = 0;
    cyc <= 1'h1;
    we <= w;
    adr <= a;
    wd <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'h1 && ++n < 20);
    q = rdat;
    if (ack !== 1'h1) chk("ack", 0, 1);
    if (ack !== 1'h1) final_report();
    cyc <= 1'h0;
    @(posedge clk);
  endtask : acc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'h1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'h0, a, 8'h00);
    chk($sformatf("reg %h", a), q, {24'h0, e});
  endtask : rd
  task automatic wdClear();
    wdc <= 1'h1;
    @(posedge clk);
    wdc <= 1'h0;
  endtask : wdClear
  initial
  begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    rd(ADDR_OPTION, OPTION_RESET);
    rd(8'h40, 8'h00);
    wr(ADDR_OPTION, 8'h08);
    wr(ADDR_COUNT, 8'h10);
    rd(ADDR_COUNT, 8'h10);
    rd(ADDR_COUNT, 8'h13);
    sleep <= 1'h1;
    wr(ADDR_COUNT, 8'h50);
    repeat (9) @(posedge clk);
    rd(ADDR_COUNT, 8'h50);
    sleep <= 1'h0;
    wr(ADDR_IRQ_CTRL, 8'h20);
    wr(ADDR_COUNT, 8'hFE);
    repeat (3) @(posedge clk);
    rd(ADDR_IRQ_CTRL, 8'h24);
    chk("irq", irq, 1);
    wr(ADDR_IRQ_CTRL, 8'h00);
    chk("irq", irq, 0);
    repeat (260) @(posedge clk);
    rd(ADDR_IRQ_CTRL, 8'h04);
    wr(ADDR_ENABLE, 8'h01);
    chk("irq", irq, 1);
    wr(ADDR_CLEAR, 8'h01);
    chk("irq", irq, 0);
    for (int e = 0; e < 2; e++)
    begin
      wr(ADDR_OPTION, e ? 8'h38 : 8'h28);
      wr(ADDR_COUNT, 8'h00);
      pin <= 1'h1;
      repeat (8) @(posedge clk);
      rd(ADDR_COUNT, e ? 8'h00 : 8'h01);
      pin <= 1'h0;
      repeat (8) @(posedge clk);
      rd(ADDR_COUNT, 8'h01);
    end
    wr(ADDR_OPTION, 8'h07);
    ticks = 0;
    repeat (3)
    begin
      wr(ADDR_COUNT, 8'h00);
      repeat (150) @(posedge clk);
      rd(ADDR_COUNT, 8'h00);
    end
    chk("tick", ticks, 0);
    // safe hand-over to the watchdog side
    wdClear();
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_OPTION, 8'h0F);
    ticks = 0;
    repeat (5)
    begin
      wdClear();
      repeat (100) @(posedge clk);
    end
    chk("tick", ticks, 0);
    repeat (600) @(posedge clk);
    chk("tick", ticks > 0, 1);
    // hand the prescaler back to the timer at 1:16
    wdClear();
    wr(ADDR_OPTION, 8'h03);
    wr(ADDR_COUNT, 8'h00);
    repeat (20) @(posedge clk);
    rd(ADDR_COUNT, 8'h01);
    final_report();
  end
endmodule : tb
`default_nettype wire

// ---- sim/tmz_pin_src.sv ----
// count pin source standing in for the outside signal
// assumes the bench holds each level for many clocks
`default_nettype none
module tmz_pin_src
(
  input wire logic clk,
  input wire logic wantHigh,
  output var logic extCount
);
  timeunit 1ns;
  timeprecision 100ps;
  initial extCount = 1'h0;
  // moves only at clk; long levels so the sampler never misses one
  always @(posedge clk) extCount <= wantHigh;
endmodule : tmz_pin_src
`default_nettype wire

// ---- sim/tmz_timer_properties.sv ----
// checker for tmz_timer ports: bus handshake, read data, interrupt line
// assumes it is bound onto every tmz_timer instance
`default_nettype none
module tmz_timer_properties
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic sleepMode,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 100ps;
  import tmz_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  AST_ACK_NEXT: assert property (wb_cyc_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i)) else $error("ack unasked");
  AST_IDLE: assert property (!wb_cyc_i ##1 !wb_cyc_i |-> !wb_ack_o) else $error("ack idle");
  AST_HIGH_ZERO: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("high bits");
  AST_HIDDEN: assert property (wb_ack_o && wb_adr_i > ADDR_ENABLE |-> wb_dat_o == 32'h0) else $error("hole");
  AST_IRQ_KEPT: assert property ($fell(irq) |-> $past(wb_cyc_i && wb_we_i)) else $error("irq lost");
  AST_SLEEP: assert property (sleepMode && $past(sleepMode) && !$past(wb_cyc_i) |-> !$rose(irq)) else $error("irq");
  cover property ($rose(irq));
  cover property (sleepMode && wb_ack_o);
  cover property (wb_ack_o && wb_adr_i > ADDR_ENABLE);
endmodule : tmz_timer_properties
bind tmz_timer tmz_timer_properties i_tmz_timer_properties (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sleepMode(sleepMode), .irq(irq));
`default_nettype wire

// ---- src/tmz_pkg.sv ----
// package for the timer/counter block with shared prescaler
// assumes a classic wishbone slave with 32-bit data, byte addresses
`default_nettype none
package tmz_pkg;
  localparam logic [7:0] ADDR_COUNT = 8'h00;
  localparam logic [7:0] ADDR_OPTION = 8'h04;
  localparam logic [7:0] ADDR_IRQ_CTRL = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_CLEAR = 8'h10;
  localparam logic [7:0] ADDR_ENABLE = 8'h14;
  localparam logic [7:0] OPTION_RESET = 8'hFF;
  localparam int OPT_SRC_BIT = 5;
  localparam int OPT_EDGE_BIT = 4;
  localparam int OPT_ASSIGN_BIT = 3;
  localparam int IRQC_FLAG_BIT = 2;
  localparam int IRQC_EN_BIT = 5;
  localparam logic [1:0] WRITE_HOLD = 2'h2;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam int PRE_W = 8;
  typedef struct packed {
    logic srcSelect;
    logic edgeSelect;
    logic prescalerAssign;
    logic [2:0] prescaleRate;
  } tmz_opt_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK = 2'b10
  } tmz_bus_t;
endpackage : tmz_pkg
`default_nettype wire

// ---- src/tmz_timer.sv ----
// 8-bit timer/counter with prescaler shared with a watchdog, wishbone slave
// assumes clk is the instruction cycle clock; extCount is an asynchronous pin
`default_nettype none
module tmz_timer
  import tmz_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic extCount,
  input wire logic sleepMode,
  input wire logic watchdogClearInstr,
  output logic watchdogTick,
  output logic irq
);
  import tmz_pkg::*;

  // rate decode below serves an 8-bit prescaler with a 3-bit rate field only
  if (PRE_W != 8)
  begin : g_preWidthCheck
    $error("prescaler width must be 8");
  end

  // counter state
  logic [7:0] countReg;
  logic [1:0] holdCnt;

  // option register, reset to all ones
  logic [7:0] optionReg;

  // interrupt state
  logic flag;
  logic flagEnable;
  logic [0:0] statusSticky;
  logic [0:0] irqEnable;

  // shared prescaler
  logic [PRE_W-1:0] prescaler;

  // count pin synchroniser and edge history
  logic sync1;
  logic sync2;
  logic syncPrev;

  // bus slave
  logic [31:0] rdData;
  tmz_bus_t busState;

  // next values
  logic [7:0] next_countReg;
  logic [1:0] next_holdCnt;
  logic [7:0] next_optionReg;

  logic next_flag;
  logic next_flagEnable;
  logic [0:0] next_statusSticky;
  logic [0:0] next_irqEnable;

  logic [PRE_W-1:0] next_prescaler;

  logic next_sync1;
  logic next_sync2;
  logic next_syncPrev;

  logic [31:0] next_rdData;
  tmz_bus_t next_busState;

  // decoded controls and datapath
  tmz_opt_t opt;
  logic [PRE_W-1:0] preMask;
  logic busWr;
  logic busRd;
  logic wrLane0;
  logic srcEvent;
  logic preOut;
  logic tick;
  logic wrap;
  logic [PRE_W-1:0] preInc;

  assign opt = tmz_opt_t'(optionReg[5:0]);
  // request taken only in idle, so a held request acts again every other cycle
  assign busWr = wb_cyc_i && wb_stb_i && wb_we_i && (busState == ST_IDLE);
  assign busRd = wb_cyc_i && wb_stb_i && !wb_we_i && (busState == ST_IDLE);
  assign wrLane0 = busWr && wb_sel_i[0];
  assign wb_ack_o = (busState == ST_ACK);
  assign wb_dat_o = rdData;

  // pin input through two flops before any edge logic
  // only the second flop and syncPrev feed the edge detector; the first may be metastable
  always_comb
  begin
    next_sync1 = extCount;
    next_sync2 = sync1;
    next_syncPrev = sync2;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      syncPrev <= 1'b0;
    end
    else
    begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      syncPrev <= next_syncPrev;
    end
  end

  always_comb
  begin
    if (!opt.srcSelect)
      srcEvent = 1'b1;
    else if (!opt.edgeSelect)
      srcEvent = sync2 && !syncPrev;
    else
      srcEvent = !sync2 && syncPrev;
  end

  // prescaler is a free counter; a ratio of 2^(rate+1) ends when the low rate+1 bits are all ones
  // a mask, not a bit toggle, so the first period after a clear is full length
  assign preInc = prescaler + PRE_W'(1);

  for (genvar b = 0; b < PRE_W; b++)
  begin : g_preMask
    assign preMask[b] = (3'(b) <= opt.prescaleRate);
  end

  assign preOut = &(prescaler | ~preMask);

  always_comb
  begin
    next_prescaler = prescaler;
    if (!sleepMode && srcEvent)
      next_prescaler = preInc;
    if (!opt.prescalerAssign && wrLane0 && wb_adr_i == ADDR_COUNT)
      next_prescaler = '0;
    if (opt.prescalerAssign && watchdogClearInstr)
      next_prescaler = '0;
  end

  // divided tick goes to the watchdog only when it owns the prescaler
  assign watchdogTick = opt.prescalerAssign && !sleepMode && srcEvent && preOut;

  always_comb
  begin
    if (sleepMode || holdCnt != 2'h0)
      tick = 1'b0;
    else if (opt.prescalerAssign)
      tick = srcEvent;
    else
      tick = srcEvent && preOut;
  end
  assign wrap = tick && countReg == COUNT_MAX;

  always_comb
  begin
    next_countReg = countReg;
    next_holdCnt = (holdCnt != 2'h0) ? holdCnt - 2'h1 : 2'h0;
    next_optionReg = optionReg;
    next_flag = flag;
    next_flagEnable = flagEnable;
    next_statusSticky = statusSticky;
    next_irqEnable = irqEnable;

    if (tick)
      next_countReg = countReg + 8'h01;

    // only the low lane carries a register byte
    if (wrLane0)
    begin
      unique case (wb_adr_i)
        ADDR_COUNT:
        begin
          next_countReg = wb_dat_i[7:0];
          next_holdCnt = WRITE_HOLD;
        end
        ADDR_OPTION: next_optionReg = wb_dat_i[7:0];
        ADDR_IRQ_CTRL:
        begin
          next_flag = wb_dat_i[IRQC_FLAG_BIT];
          next_flagEnable = wb_dat_i[IRQC_EN_BIT];
        end
        ADDR_CLEAR: next_statusSticky = statusSticky & ~wb_dat_i[0:0];
        ADDR_ENABLE: next_irqEnable = wb_dat_i[0:0];
        default: ;
      endcase
    end

    // set beats a same-cycle software clear
    if (wrap)
    begin
      next_flag = 1'b1;
      next_statusSticky = 1'b1;
    end
  end

  always_comb
  begin
    next_rdData = 32'h0000_0000;
    next_busState = ST_IDLE;
    if (busRd)
    begin
      unique case (wb_adr_i)
        ADDR_COUNT: next_rdData = {24'h00_0000, countReg};
        ADDR_OPTION: next_rdData = {24'h00_0000, optionReg};
        ADDR_IRQ_CTRL: next_rdData = {26'h000_0000, flagEnable, 2'h0, flag, 2'h0};
        ADDR_STATUS: next_rdData = {31'h0000_0000, statusSticky};
        ADDR_ENABLE: next_rdData = {31'h0000_0000, irqEnable};
        default: next_rdData = 32'h0000_0000;
      endcase
    end

    // every access answers one cycle later, mapped or not
    if (busRd || busWr)
      next_busState = ST_ACK;
  end

  // prescaler group
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      prescaler <= '0;
    end
    else
    begin
      prescaler <= next_prescaler;
    end
  end

  // counter, option and interrupt group
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      countReg <= 8'h00;
      optionReg <= OPTION_RESET;
      flag <= 1'b0;
      flagEnable <= 1'b0;
      statusSticky <= 1'b0;
      irqEnable <= 1'b0;
      holdCnt <= 2'h0;
    end
    else
    begin
      countReg <= next_countReg;
      optionReg <= next_optionReg;
      flag <= next_flag;
      flagEnable <= next_flagEnable;
      statusSticky <= next_statusSticky;
      irqEnable <= next_irqEnable;
      holdCnt <= next_holdCnt;
    end
  end

  // bus group
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rdData <= 32'h0000_0000;
      busState <= ST_IDLE;
    end
    else
    begin
      rdData <= next_rdData;
      busState <= next_busState;
    end
  end

  // sleep cannot wake through this path: nothing wraps while frozen
  assign irq = (flag && flagEnable) || (statusSticky[0] && irqEnable[0]);
endmodule : tmz_timer
`default_nettype wire
